// ==== rtl/fivi_top.sv ====
// Image check and install command handler with register port and flash store
`timescale 1ns/1ps
module fivi_top #(
    parameter int NBYTES = fivi_pkg::STORE_BYTES,
    parameter int BLKB = fivi_pkg::BLOCK_BYTES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Command requests
    input wire logic req_valid_i,
    input wire fivi_pkg::fivi_req_s req_i,
    // Replies
    output logic rsp_valid_o,
    output fivi_pkg::fivi_rsp_s rsp_o,
    // User flash operations
    input wire fivi_pkg::fivi_fop_s fop_i,
    // Device control
    output logic sys_reset_o,
    output logic boot_new_o,
    output logic busy_o,
    // Register port
    input wire logic [fivi_pkg::AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Interrupt
    output logic irq_o
);
    import fivi_pkg::*;

    typedef struct packed {
        fivi_state_e st;
        logic install;
        logic unicast;
        logic [7:0] src_ep;
        logic ctrl_en;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] mask;
        logic [31:0] rdata;
        logic irq;
        fivi_rsp_s rsp;
        logic rsp_valid;
        logic chk_start;
        logic valid;
        logic boot_new;
        logic sys_rst;
        logic [7:0] cnt;
        logic busy;
    } fivi_top_s;

    fivi_top_s s_r;
    fivi_top_s s_nxt;

    logic chk_done;
    logic chk_valid;
    logic [15:0] chk_addr;
    logic [7:0] store_data;
    fivi_fop_s store_op;
    logic erase_all;
    logic cmd_known;
    logic req_take;
    logic fop_any;
    logic [EV_W-1:0] ev;

    fivi_flash_store #(
        .NBYTES(NBYTES),
        .BLKB(BLKB)
    ) u_store (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .op_i(store_op),
        .erase_all_i(erase_all),
        .rd_addr_i(chk_addr),
        .rd_data_o(store_data)
    );

    fivi_image_check #(
        .NBYTES(NBYTES)
    ) u_check (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(s_r.chk_start),
        .done_o(chk_done),
        .valid_o(chk_valid),
        .rd_addr_o(chk_addr),
        .rd_data_i(store_data)
    );

    // Only the two check codes are taken; other codes belong to other handlers
    always_comb begin
        cmd_known = (req_i.cmd == CMD_CHECK) || (req_i.cmd == CMD_CHECK_INSTALL);
    end

    always_comb begin
        req_take = req_valid_i && cmd_known && s_r.ctrl_en && (s_r.st == ST_IDLE);
    end

    always_comb begin
        fop_any = fop_i.wr || fop_i.erase;
    end

    // User flash access only while idle and no check request is taken
    always_comb begin
        store_op = '0;
        if (s_r.st == ST_IDLE && !req_take) begin
            store_op = fop_i;
        end
    end

    always_comb begin
        erase_all = (s_r.st == ST_ERASE);
    end

    // Events seen this cycle
    always_comb begin
        ev = '0;
        ev[EV_CHECK] = chk_done && (s_r.st == ST_CHECK);
        ev[EV_INSTALL] = chk_done && (s_r.st == ST_CHECK) && s_r.install && chk_valid;
        ev[EV_REFUSED] = (fop_any && (s_r.st != ST_IDLE || req_take))
            || (req_valid_i && cmd_known && s_r.ctrl_en && s_r.st != ST_IDLE);
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.chk_start = 1'b0;
        s_nxt.sys_rst = 1'b0;

        case (s_r.st)
            ST_IDLE: begin
                if (req_take) begin
                    // Option, block, offset and count are not read
                    s_nxt.install = (req_i.cmd == CMD_CHECK_INSTALL);
                    s_nxt.unicast = req_i.unicast;
                    s_nxt.src_ep = req_i.src_ep;
                    s_nxt.chk_start = 1'b1;
                    s_nxt.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (chk_done) begin
                    // Same checker result feeds both commands
                    s_nxt.valid = chk_valid;
                    s_nxt.rsp = '0;
                    s_nxt.rsp.dst_ep = s_r.src_ep;
                    if (!s_r.install) begin
                        s_nxt.rsp.cmd = RSP_CHECK;
                        s_nxt.rsp.result[RES_INVALID_BIT] = !chk_valid;
                        s_nxt.rsp_valid = s_r.unicast;
                        s_nxt.st = ST_IDLE;
                    end else if (!chk_valid) begin
                        s_nxt.rsp.cmd = RSP_CHECK_INSTALL;
                        s_nxt.rsp.result[RES_INVALID_BIT] = 1'b1;
                        s_nxt.rsp_valid = s_r.unicast;
                        s_nxt.st = ST_IDLE;
                    end else begin
                        // Valid image: no reply, go install
                        s_nxt.boot_new = 1'b1;
                        s_nxt.st = ST_ERASE;
                    end
                end
            end
            ST_ERASE: begin
                // Store cleared in this cycle by erase_all
                s_nxt.cnt = 8'(REBOOT_CYCLES);
                s_nxt.sys_rst = 1'b1;
                s_nxt.st = ST_REBOOT;
            end
            ST_REBOOT: begin
                if (s_r.cnt > 8'h01) begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                    s_nxt.sys_rst = 1'b1;
                end else begin
                    s_nxt.cnt = 8'h00;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        s_nxt.busy = (s_nxt.st != ST_IDLE);

        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_CTRL: begin
                    s_nxt.ctrl_en = reg_wdata_i[CTRL_EN_BIT];
                end
                ADDR_MASK: begin
                    s_nxt.mask = reg_wdata_i[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data one cycle later
        s_nxt.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CTRL: begin
                    s_nxt.rdata[CTRL_EN_BIT] = s_r.ctrl_en;
                end
                ADDR_STATUS: begin
                    s_nxt.rdata[EV_W-1:0] = s_r.sts;
                end
                ADDR_MASK: begin
                    s_nxt.rdata[EV_W-1:0] = s_r.mask;
                end
                ADDR_STATE: begin
                    s_nxt.rdata[0] = s_r.valid;
                    s_nxt.rdata[1] = s_r.busy;
                    s_nxt.rdata[2] = s_r.boot_new;
                    s_nxt.rdata[6:4] = s_r.st;
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Sticky status: read clears, a new event in the same cycle wins
        if (reg_rd_i && reg_addr_i == ADDR_STATUS) begin
            s_nxt.sts = ev;
        end else begin
            s_nxt.sts = s_r.sts | ev;
        end

        s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.ctrl_en <= CTRL_EN_RST;
            s_r.mask <= MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rsp_valid_o = s_r.rsp_valid;
    assign rsp_o = s_r.rsp;
    assign sys_reset_o = s_r.sys_rst;
    assign boot_new_o = s_r.boot_new;
    assign busy_o = s_r.busy;
    assign reg_rdata_o = s_r.rdata;
    assign irq_o = s_r.irq;
endmodule

// ==== shared/fivi_pkg.sv ====
// Constants and types shared by the flash image check and install block
// Functional notes
// - Command code 0x05 asks for an image check and 0x06 for an image check then install, each decoded apart.
// - Either check command makes the device examine the flash store for a valid update image.
// - A check-and-install that finds a valid image resets the device and starts the new firmware.
// - A unicast check request is answered with code 0x85 sent to the request's source endpoint.
// - In the 0x85 reply result bit 0 is 1 for no valid image and 0 for a valid one, other bits reserved.
// - A unicast check-and-install request is answered with code 0x86 only when the image is not valid.
// - In the 0x86 reply result bit 0 is 1 to report an invalid image, other bits reserved.
// - Both replies carry zero block index, byte offset and byte count and no payload.
// - A flash write can only clear bits to zero; only an erase sets them back to one.
// - An erase always clears one whole flash block, never part of one.
// - A firmware upgrade erases the whole flash store, losing any user data in it.
package fivi_pkg;
    localparam logic [7:0] CMD_CHECK = 8'h05;
    localparam logic [7:0] CMD_CHECK_INSTALL = 8'h06;
    localparam logic [7:0] RSP_CHECK = 8'h85;
    localparam logic [7:0] RSP_CHECK_INSTALL = 8'h86;
    localparam int RES_INVALID_BIT = 0;
    localparam logic [7:0] IMG_MAGIC = 8'hA5;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int STORE_BLOCKS = 4;
    localparam int BLOCK_BYTES = 16;
    localparam int STORE_BYTES = STORE_BLOCKS * BLOCK_BYTES;
    localparam int AW = 8;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [AW-1:0] ADDR_MASK = 8'h08;
    localparam logic [AW-1:0] ADDR_STATE = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int EV_CHECK = 0;
    localparam int EV_INSTALL = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REBOOT_PULSE_NS = 100;
    localparam int REBOOT_CYCLES = (REBOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] options;
        logic [15:0] block;
        logic [15:0] offset;
        logic [15:0] count;
        logic [7:0] src_ep;
        logic unicast;
    } fivi_req_s;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] result;
        logic [15:0] block;
        logic [15:0] offset;
        logic [15:0] count;
        logic [7:0] dst_ep;
    } fivi_rsp_s;

    typedef struct packed {
        logic wr;
        logic erase;
        logic [15:0] addr;
        logic [7:0] data;
    } fivi_fop_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_ERASE = 3'b010,
        ST_REBOOT = 3'b011
    } fivi_state_e;
endpackage

// ==== rtl/fivi_flash_store.sv ====
// Byte-wide flash store model with write-clears-only and whole-block erase
`timescale 1ns/1ps
module fivi_flash_store #(
    parameter int NBYTES = fivi_pkg::STORE_BYTES,
    parameter int BLKB = fivi_pkg::BLOCK_BYTES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Operations
    input wire fivi_pkg::fivi_fop_s op_i,
    input wire logic erase_all_i,
    // Read port
    input wire logic [15:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    import fivi_pkg::*;

    typedef struct packed {
        logic [NBYTES-1:0][7:0] mem;
    } fivi_store_s;

    fivi_store_s s_r;
    fivi_store_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < NBYTES; i++) begin
            if (erase_all_i) begin
                s_nxt.mem[i] = ERASED_BYTE;
            end else if (op_i.erase && (i / BLKB) == (int'(op_i.addr) / BLKB)) begin
                s_nxt.mem[i] = ERASED_BYTE;
            end else if (op_i.wr && i == int'(op_i.addr)) begin
                s_nxt.mem[i] = s_r.mem[i] & op_i.data;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '{mem: {NBYTES{ERASED_BYTE}}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_o = (int'(rd_addr_i) < NBYTES) ? s_r.mem[rd_addr_i] : ERASED_BYTE;
endmodule

// ==== rtl/fivi_image_check.sv ====
// Scans the flash store and decides whether it holds a valid update image
`timescale 1ns/1ps
module fivi_image_check #(
    parameter int NBYTES = fivi_pkg::STORE_BYTES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic start_i,
    output logic done_o,
    output logic valid_o,
    // Store read port
    output logic [15:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);
    import fivi_pkg::*;

    typedef struct packed {
        logic busy;
        logic [15:0] idx;
        logic [7:0] sum;
        logic magic_ok;
        logic done;
        logic valid;
    } fivi_chk_s;

    fivi_chk_s s_r;
    fivi_chk_s s_nxt;

    // Valid means a leading marker byte and a zero byte sum over the store
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start_i && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.idx = 16'h0000;
            s_nxt.sum = 8'h00;
        end else if (s_r.busy) begin
            s_nxt.sum = s_r.sum + rd_data_i;
            s_nxt.idx = s_r.idx + 16'h0001;
            if (s_r.idx == 16'h0000) begin
                s_nxt.magic_ok = (rd_data_i == IMG_MAGIC);
            end
            if (int'(s_r.idx) == NBYTES - 1) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.valid = s_r.magic_ok && (8'(s_r.sum + rd_data_i) == 8'h00);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_addr_o = s_r.idx;
    assign done_o = s_r.done;
    assign valid_o = s_r.valid;
endmodule

// ==== testbench/fivi_monitor.sv ====
// Port checker for the image check and install block
`timescale 1ns/1ps
module fivi_monitor #(
    parameter int NBYTES = 64
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire fivi_pkg::fivi_req_s req_i,
    input wire logic rsp_valid_o,
    input wire fivi_pkg::fivi_rsp_s rsp_o,
    input wire logic busy_o,
    input wire logic sys_reset_o,
    input wire logic boot_new_o,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o
);
    import fivi_pkg::*;
    localparam int LAT = NBYTES + 2;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    rsp_code_a: assert property (rsp_valid_o |-> rsp_o.cmd == RSP_CHECK || rsp_o.cmd == RSP_CHECK_INSTALL)
        else $error("reply code is not a check reply");
    rsp_zero_a: assert property (rsp_valid_o |-> rsp_o.block == 16'h0 && rsp_o.offset == 16'h0 && rsp_o.count == 16'h0)
        else $error("reply fields not zero");
    inst_invalid_a: assert property (rsp_valid_o && rsp_o.cmd == RSP_CHECK_INSTALL |-> rsp_o.result[0])
        else $error("install reply without invalid flag");
    check_lat_a: assert property ($rose(busy_o) && $past(req_i.cmd) == CMD_CHECK && $past(req_i.unicast) |-> ##LAT rsp_valid_o)
        else $error("check reply missing or late");
    boot_quiet_a: assert property ($rose(boot_new_o) |-> !rsp_valid_o)
        else $error("reply sent with install");
    rst_pulse_a: assert property ($rose(sys_reset_o) |-> sys_reset_o[*8] ##1 sys_reset_o ##1 sys_reset_o ##1 !sys_reset_o)
        else $error("reset pulse length wrong");
    rst_boot_a: assert property (sys_reset_o |-> boot_new_o)
        else $error("reset without new firmware");
    busy_end_a: assert property (rsp_valid_o |-> $past(busy_o) && !busy_o)
        else $error("reply not at end of check");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
endmodule
bind fivi_top fivi_monitor #(.NBYTES(NBYTES)) u_mon (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .busy_o(busy_o), .sys_reset_o(sys_reset_o), .boot_new_o(boot_new_o),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

// ==== testbench/fivi_requester.sv ====
// Remote requester model issuing image check commands
`timescale 1ns/1ps
module fivi_requester (
    input wire logic core_clk_i,
    output logic req_valid_o,
    output fivi_pkg::fivi_req_s req_o
);
    import fivi_pkg::*;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic send(input logic [7:0] cmd, input logic [7:0] ep, input logic uni);
        fivi_req_s r;
        r = '0;
        r.cmd = cmd;
        r.src_ep = ep;
        r.unicast = uni;
        @(posedge core_clk_i);
        req_valid_o <= 1'b1;
        req_o <= r;
        @(posedge core_clk_i);
        req_valid_o <= 1'b0;
        req_o <= fivi_req_s'(~r);
    endtask
endmodule

// ==== testbench/test_fivi_top.sv ====
// Self-checking testbench for the image check and install block
`timescale 1ns/1ps
module test_fivi_top;
    import fivi_pkg::*;
    logic core_clk_i, nrst_i, req_valid_i, rsp_valid_o, sys_reset_o, boot_new_o, busy_o, reg_wr_i, reg_rd_i, irq_o;
    fivi_req_s req_i;
    fivi_rsp_s rsp_o;
    fivi_fop_s fop_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    int n_mismatch = 0;
    int compares = 0;
    int nrsp, at, nrs;
    localparam int NBYTES_T = 64;
    fivi_top u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .fop_i(fop_i), .sys_reset_o(sys_reset_o), .boot_new_o(boot_new_o),
        .busy_o(busy_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
    fivi_requester u_req (.core_clk_i(core_clk_i), .req_valid_o(req_valid_i), .req_o(req_i));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o === exp, "register read value");
    endtask
    task automatic fop(input logic w, input logic e, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        fop_i <= '{w, e, a, d};
        @(posedge core_clk_i);
        fop_i <= '0;
    endtask
    // Issue a command (twice when dup) and watch replies and reset pulse for 80 cycles
    task automatic run(input logic [7:0] cmd, input logic [7:0] ep, input logic uni, input logic dup);
        nrsp = 0;
        at = 0;
        nrs = 0;
        u_req.send(cmd, ep, uni);
        if (dup) begin
            u_req.send(cmd, ep, uni);
        end
        for (int i = 1; i <= 80; i++) begin
            @(posedge core_clk_i);
            #1;
            if (rsp_valid_o === 1'b1) begin
                nrsp++;
                at = i;
            end
            if (sys_reset_o === 1'b1) begin
                nrs++;
            end
        end
    endtask
    task automatic t_reset();
        chk({rsp_valid_o, busy_o, sys_reset_o, boot_new_o, irq_o} === 5'h0, "outputs after reset");
        rd_reg(ADDR_CTRL, 32'h1);
        rd_reg(ADDR_MASK, 32'h0);
        rd_reg(8'h10, 32'h0);
    endtask
    task automatic t_invalid();
        wr_reg(ADDR_MASK, 32'h1);
        run(CMD_CHECK, 8'h21, 1'b1, 1'b0);
        chk(nrsp === 1 && at === NBYTES_T + 2, "check reply timing");
        chk(rsp_o === fivi_rsp_s'{RSP_CHECK, 8'h01, 16'h0, 16'h0, 16'h0, 8'h21}, "check reply invalid");
        chk(irq_o === 1'b1, "irq after check");
        rd_reg(ADDR_STATUS, 32'h1);
        chk(irq_o === 1'b0, "irq after status read");
        run(CMD_CHECK_INSTALL, 8'h22, 1'b1, 1'b0);
        chk(nrsp === 1 && nrs === 0, "install reply on invalid");
        chk(rsp_o === fivi_rsp_s'{RSP_CHECK_INSTALL, 8'h01, 16'h0, 16'h0, 16'h0, 8'h22}, "install reply");
    endtask
    task automatic t_write();
        fop(1'b1, 1'b0, 16'h0, 8'h00);
        fop(1'b1, 1'b0, 16'h0, 8'hA5);
        fop(1'b1, 1'b0, 16'h1, 8'h99);
        run(CMD_CHECK, 8'h21, 1'b1, 1'b0);
        chk(rsp_o.result === 8'h01, "write set bits");
        fop(1'b0, 1'b1, 16'h5, 8'h00);
        fop(1'b1, 1'b0, 16'h0, 8'hA5);
        fop(1'b1, 1'b0, 16'h1, 8'h99);
        run(CMD_CHECK, 8'h21, 1'b1, 1'b0);
        chk(rsp_o.result === 8'h00, "valid image after block erase");
    endtask
    task automatic t_refused();
        run(CMD_CHECK, 8'h24, 1'b1, 1'b1);
        chk(nrsp === 1, "second request while busy");
        rd_reg(ADDR_STATUS, 32'h5);
    endtask
    task automatic t_ignored();
        u_req.send(8'h04, 8'h25, 1'b1);
        @(posedge core_clk_i);
        #1;
        chk(busy_o === 1'b0, "unknown code taken");
        wr_reg(ADDR_CTRL, 32'h0);
        u_req.send(CMD_CHECK, 8'h25, 1'b1);
        @(posedge core_clk_i);
        #1;
        chk(busy_o === 1'b0, "request taken while disabled");
        wr_reg(ADDR_CTRL, 32'h1);
        rd_reg(ADDR_CTRL, 32'h1);
        run(CMD_CHECK, 8'h25, 1'b0, 1'b0);
        chk(nrsp === 0, "reply to broadcast");
    endtask
    task automatic t_install();
        run(CMD_CHECK_INSTALL, 8'h23, 1'b1, 1'b0);
        chk(nrsp === 0 && nrs === REBOOT_CYCLES && boot_new_o === 1'b1, "install on valid image");
        rd_reg(ADDR_STATE, 32'h5);
        run(CMD_CHECK, 8'h26, 1'b1, 1'b0);
        chk(rsp_o.result === 8'h01, "store not erased by install");
    endtask
    initial begin
        nrst_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        fop_i = '0;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        t_reset();
        t_invalid();
        t_write();
        t_refused();
        t_ignored();
        t_install();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
